// [sfbp_regs.svh]
// Purpose: Constants of the serial flash block protection logic
// Assumes: Included by the package and the design module
// Notes:   Block index 0 is the lowest address; read locks sit above write locks
`ifndef SFBP_REGS_SVH
`define SFBP_REGS_SVH

`define SFBP_SECTOR_BYTES   4096
`define SFBP_PARAM_BYTES    8192
`define SFBP_OVL32_BYTES    32768
`define SFBP_OVL64_BYTES    65536
`define SFBP_NUM_PARAM      8
`define SFBP_NUM_OVL32      2
`define SFBP_NUM_OVL64      126
`define SFBP_ADDR_W         23
`define SFBP_BPR_W          144
`define SFBP_PLK_W          136
`define SFBP_RLOCK_LSB      136
`define SFBP_TOP_PARAM_IDX  132
`define SFBP_TOP_OVL32_IDX  131
`define SFBP_BOT_OVL32_IDX  4
`define SFBP_MID_BASE_IDX   4
`define SFBP_TOP_REGION     7'h7f
`define SFBP_BPR_RESET      {8'h00, {136{1'b1}}}
`define SFBP_DATA_ZERO      8'h00
`define SFBP_SYNC_STAGES    3

`endif

// [sfbp_pkg.sv]
// Purpose: Types shared by the block protection logic
// Assumes: sfbp_regs.svh holds the numeric constants
// Notes:   Command codes are the decoder's, one per protection action
`include "sfbp_regs.svh"

package sfbp_pkg;
  typedef enum logic [3:0] {
    SFBP_CMD_NONE     = 4'h0,
    SFBP_CMD_WRITE_ENABLE_CMD     = 4'h1,
    SFBP_CMD_WRDI     = 4'h2,
    SFBP_CMD_WRITE_PROTECTION_CMD     = 4'h3,
    SFBP_CMD_PROTECTION_LOCKDOWN_CMD     = 4'h4,
    SFBP_CMD_GUNLOCK  = 4'h5,
    SFBP_CMD_WPLK     = 4'h6,
    SFBP_CMD_WCFG     = 4'h7,
    SFBP_CMD_EQUAD    = 4'h8,
    SFBP_CMD_XQUAD    = 4'h9
  } sfbp_cmd_t;

  typedef enum logic [1:0] {
    SFBP_ST_IDLE  = 2'b01,
    SFBP_ST_APPLY = 2'b10
  } sfbp_state_t;
endpackage

// [sfbp_core.sv]
// Purpose: Block write/read protection, volatile lock-down and permanent lock bits
// Assumes: A command decoder on the serial clock hands over decoded commands
// Notes:   Non-volatile bits keep their value across rst_n_in; only factory_rst_n_in
//          returns them to factory state
// Behaviour
// - Array is 4K sectors; 8 param 8K, 2 overlay 32K, 126 overlay 64K blocks.
// - Start single-line after reset; four-line only after enter-quad command.
// - Both clock idle levels accepted; logic uses rising edges only.
// - Link data sampled on serial clock rising edge.
// - All blocks write-protected after power-on reset.
// - 144-bit protection register: two bits per param block, one per other block.
// - One means protected; param pair has read lock upper, write lock lower.
// - Reads of a read-locked parameter block return 00H.
// - Protection write accepted only with write enable latch set.
// - Global unlock clears at once every write-lock bit whose permanent lock bit is zero.
// - Lock-down needs write enable; afterwards protection register is frozen.
// - Lock-down cleared only by power cycle; shown as a status flag.
// - Non-volatile 136-bit lock register, one bit per block.
// - Writing one sets lock bit and write lock permanently.
// - Writing zero to a lock bit changes nothing.
// - Permanent lock write ignored while lock-down is active.
// - Pin protection works only in single/dual mode with pin-config zero.
// - Pin-config one disables pin and pin-enable bit.
// - Pin-enable zero ignores pin; pin-enable is non-volatile.
// - Config zero, enable one, pin low blocks protection and config writes.
// - Lock-down refuses protection writes regardless of pin and config.
// - Pin guards only protection and config registers, not program or erase.
// - Lock-down flag set by lock-down command, cleared only by power cycle.
// - Write enable latch cleared after protection write or lock-down.
`timescale 1ns/1ps
`default_nettype none
`include "sfbp_regs.svh"

module sfbp_core #(
  parameter logic PIN_CONFIG_FACTORY = 1'b0,
  parameter logic WP_ENABLE_FACTORY  = 1'b0
) (
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      factory_rst_n_in,
  input  wire logic                      sck_in,
  input  wire logic                      link_cmd_valid_in,
  input  wire sfbp_pkg::sfbp_cmd_t       link_cmd_in,
  input  wire logic [`SFBP_BPR_W-1:0]    link_data_in,
  input  wire logic                      dual_read_mode_in,
  input  wire logic                      wp_n_in,
  input  wire logic [`SFBP_ADDR_W-1:0]   rd_addr_in,
  input  wire logic [7:0]                rd_data_in,
  output logic [7:0]                     rd_data_out,
  output logic                           wr_blocked_out,
  output logic [`SFBP_BPR_W-1:0]         block_protection_bits_out,
  output logic [`SFBP_PLK_W-1:0]         permanent_lock_bits_out,
  output logic                           lockdown_status_flag_out,
  output logic                           write_enable_latch_out,
  output logic                           wp_pin_enable_bit_out,
  output logic                           pin_config_bit_out,
  output logic                           quad_mode_out,
  output logic                           cmd_done_out,
  output logic                           cmd_refused_out
);
  import sfbp_pkg::*;

  // Block index of a byte address, lowest address first, params at both ends
  function automatic logic [7:0] block_of(input logic [`SFBP_ADDR_W-1:0] a);
    logic [6:0] region;
    region = a[22:16];
    if (region == 7'h00) begin
      block_of = a[15] ? 8'(`SFBP_BOT_OVL32_IDX) : {6'h00, a[14:13]};
    end else if (region == `SFBP_TOP_REGION) begin
      block_of = a[15] ? (8'(`SFBP_TOP_PARAM_IDX) + {6'h00, a[14:13]})
                       : 8'(`SFBP_TOP_OVL32_IDX);
    end else begin
      block_of = 8'(`SFBP_MID_BASE_IDX) + {1'b0, region};
    end
  endfunction

  // Parameter slot (0..7) of a block index; valid only for parameter blocks
  function automatic logic [2:0] param_slot(input logic [7:0] idx);
    param_slot = (idx < 8'h04) ? idx[2:0] : (3'h4 + 3'(idx - 8'(`SFBP_TOP_PARAM_IDX)));
  endfunction

  function automatic logic is_param(input logic [7:0] idx);
    is_param = (idx < 8'h04) || (idx >= 8'(`SFBP_TOP_PARAM_IDX));
  endfunction

  // ---------------- Link domain (serial clock) ----------------
  logic                   link_tgl_r;
  sfbp_cmd_t              link_cmd_r;
  logic [`SFBP_BPR_W-1:0] link_data_r;

  // Capture on the rising edge only, so either idle level of the clock works
  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_tgl_r  <= 1'b0;
      link_cmd_r  <= SFBP_CMD_NONE;
      link_data_r <= '0;
    end else if (link_cmd_valid_in) begin
      link_tgl_r  <= ~link_tgl_r;
      link_cmd_r  <= link_cmd_in;
      link_data_r <= link_data_in;
    end
  end

  // ---------------- Crossing into clock_in ----------------
  // Toggle passes three stages; command and data are held stable by the link
  // until the next command, so they are read only after the toggle settles.
  logic [`SFBP_SYNC_STAGES-1:0] tgl_sync_r;
  logic [`SFBP_SYNC_STAGES-1:0] wp_sync_r;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_sync_r <= '0;
      wp_sync_r  <= '1;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], link_tgl_r};
      wp_sync_r  <= {wp_sync_r[1:0], wp_n_in};
    end
  end

  logic cmd_event;
  assign cmd_event = tgl_sync_r[2] ^ tgl_sync_r[1];

  // Pin level counts only once the last two stages agree
  logic wp_low_r;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_low_r <= 1'b0;
    end else if (wp_sync_r[2] == wp_sync_r[1]) begin
      wp_low_r <= ~wp_sync_r[2];
    end
  end

  // ---------------- Command sequencer ----------------
  sfbp_state_t state_r;
  sfbp_cmd_t   cmd_r;

  // One cycle to register the command before acting keeps decode shallow
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= SFBP_ST_IDLE;
      cmd_r   <= SFBP_CMD_NONE;
    end else begin
      case (state_r)
        SFBP_ST_IDLE: begin
          if (cmd_event) begin
            state_r <= SFBP_ST_APPLY;
            cmd_r   <= link_cmd_r;
          end
        end
        SFBP_ST_APPLY: begin
          state_r <= SFBP_ST_IDLE;
        end
        default: begin
          state_r <= SFBP_ST_IDLE;
        end
      endcase
    end
  end

  logic apply;
  assign apply = (state_r == SFBP_ST_APPLY);

  // ---------------- Protection state ----------------
  logic [`SFBP_BPR_W-1:0] bpr_r;
  logic [`SFBP_PLK_W-1:0] plk_r;
  logic                   lockdown_r;
  logic                   wel_r;
  logic                   wp_pin_enable_bit_r;
  logic                   ioc_r;
  logic                   quad_r;

  // Pin protection only in single/dual mode, config zero, enable one
  logic pin_guard;
  assign pin_guard = wp_low_r && !quad_r && !ioc_r && wp_pin_enable_bit_r;

  logic bpr_ok;
  assign bpr_ok = wel_r && !lockdown_r && !pin_guard;

  logic cfg_ok;
  assign cfg_ok = wel_r && !pin_guard;

  logic plk_ok;
  assign plk_ok = wel_r && !lockdown_r;

  logic [`SFBP_BPR_W-1:0] perm_mask;
  assign perm_mask = {8'h00, plk_r};

  // Block protection register; permanent lock bits always force write locks
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bpr_r <= `SFBP_BPR_RESET;
    end else if (apply && cmd_r == SFBP_CMD_WRITE_PROTECTION_CMD && bpr_ok) begin
      bpr_r <= link_data_r | perm_mask;
    end else if (apply && cmd_r == SFBP_CMD_GUNLOCK && bpr_ok) begin
      bpr_r <= {bpr_r[`SFBP_BPR_W-1:`SFBP_RLOCK_LSB], {`SFBP_PLK_W{1'b0}}}
               | perm_mask;
    end else if (apply && cmd_r == SFBP_CMD_WPLK && plk_ok) begin
      bpr_r <= bpr_r | {8'h00, link_data_r[`SFBP_PLK_W-1:0]};
    end
  end

  // Permanent lock bits: ones only accumulate, zeros are no-ops
  always_ff @(posedge clock_in or negedge factory_rst_n_in) begin
    if (!factory_rst_n_in) begin
      plk_r <= '0;
    end else if (apply && cmd_r == SFBP_CMD_WPLK && plk_ok) begin
      plk_r <= plk_r | link_data_r[`SFBP_PLK_W-1:0];
    end
  end

  // Volatile lock-down; only a power-on reset releases it
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lockdown_r <= 1'b0;
    end else if (apply && cmd_r == SFBP_CMD_PROTECTION_LOCKDOWN_CMD && wel_r) begin
      lockdown_r <= 1'b1;
    end
  end

  // Write enable latch; consumed by each protection-changing command
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wel_r <= 1'b0;
    end else if (apply) begin
      case (cmd_r)
        SFBP_CMD_WRITE_ENABLE_CMD:    wel_r <= 1'b1;
        SFBP_CMD_WRDI,
        SFBP_CMD_WRITE_PROTECTION_CMD,
        SFBP_CMD_PROTECTION_LOCKDOWN_CMD,
        SFBP_CMD_GUNLOCK,
        SFBP_CMD_WPLK,
        SFBP_CMD_WCFG:    wel_r <= 1'b0;
        default:          wel_r <= wel_r;
      endcase
    end
  end

  // Non-volatile config bits; a write never returns the enable bit to zero, only factory_rst_n_in restores it
  always_ff @(posedge clock_in or negedge factory_rst_n_in) begin
    if (!factory_rst_n_in) begin
      wp_pin_enable_bit_r <= WP_ENABLE_FACTORY;
      ioc_r  <= PIN_CONFIG_FACTORY;
    end else if (apply && cmd_r == SFBP_CMD_WCFG && cfg_ok) begin
      wp_pin_enable_bit_r <= wp_pin_enable_bit_r | link_data_r[1];
      ioc_r  <= link_data_r[0];
    end
  end

  // Bus width mode; single-line after every power-on reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quad_r <= 1'b0;
    end else if (apply && cmd_r == SFBP_CMD_EQUAD) begin
      quad_r <= 1'b1;
    end else if (apply && cmd_r == SFBP_CMD_XQUAD) begin
      quad_r <= 1'b0;
    end
  end

  // ---------------- Outputs ----------------
  logic       acted;
  logic [7:0] rd_blk;
  logic       rd_locked;

  always_comb begin
    case (cmd_r)
      SFBP_CMD_WRITE_PROTECTION_CMD,
      SFBP_CMD_GUNLOCK: acted = bpr_ok;
      SFBP_CMD_PROTECTION_LOCKDOWN_CMD:    acted = wel_r;
      SFBP_CMD_WPLK:    acted = plk_ok;
      SFBP_CMD_WCFG:    acted = cfg_ok;
      default:          acted = 1'b1;
    endcase
  end

  assign rd_blk    = block_of(rd_addr_in);
  assign rd_locked = is_param(rd_blk) && bpr_r[`SFBP_RLOCK_LSB + 32'(param_slot(rd_blk))];

  // Read path masks locked parameter data; pin plays no part here
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out    <= `SFBP_DATA_ZERO;
      wr_blocked_out <= 1'b1;
    end else begin
      rd_data_out    <= rd_locked ? `SFBP_DATA_ZERO : rd_data_in;
      wr_blocked_out <= bpr_r[rd_blk];
    end
  end

  // Command result strobes, one cycle after the apply cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_done_out    <= 1'b0;
      cmd_refused_out <= 1'b0;
    end else begin
      cmd_done_out    <= apply;
      cmd_refused_out <= apply && !acted;
    end
  end

  // Register mirrors for status reads
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      block_protection_bits_out <= `SFBP_BPR_RESET;
      permanent_lock_bits_out   <= '0;
      lockdown_status_flag_out  <= 1'b0;
      write_enable_latch_out    <= 1'b0;
      wp_pin_enable_bit_out     <= 1'b0;
      pin_config_bit_out        <= 1'b0;
      quad_mode_out             <= 1'b0;
    end else begin
      block_protection_bits_out <= bpr_r;
      permanent_lock_bits_out   <= plk_r;
      lockdown_status_flag_out  <= lockdown_r;
      write_enable_latch_out    <= wel_r;
      wp_pin_enable_bit_out     <= wp_pin_enable_bit_r;
      pin_config_bit_out        <= ioc_r;
      quad_mode_out             <= quad_r;
    end
  end

  logic unused_ok;
  assign unused_ok = dual_read_mode_in;
endmodule
`default_nettype wire

// [sfbp_core_asserts.sv]
// Purpose: Concurrent checks on the block protection core ports
// Assumes: Every watched port belongs to the clock_in domain
// Notes:   Mirrors move one cycle after the done pulse, so refusals are judged then
`timescale 1ns/1ps
`default_nettype none
`include "sfbp_regs.svh"

module sfbp_core_asserts (
  input wire logic                    clock_in,
  input wire logic                    rst_n_in,
  input wire logic                    factory_rst_n_in,
  input wire logic [`SFBP_ADDR_W-1:0] rd_addr_in,
  input wire logic [7:0]              rd_data_in,
  input wire logic [7:0]              rd_data_out,
  input wire logic                    wr_blocked_out,
  input wire logic [`SFBP_BPR_W-1:0]  block_protection_bits_out,
  input wire logic [`SFBP_PLK_W-1:0]  permanent_lock_bits_out,
  input wire logic                    lockdown_status_flag_out,
  input wire logic                    write_enable_latch_out,
  input wire logic                    cmd_done_out,
  input wire logic                    cmd_refused_out
);
  wire [143:0] block_protection_bits = block_protection_bits_out;
  wire [135:0] plk = permanent_lock_bits_out;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Lowest parameter block addressed with a steady read lock, then the registered answer
  sequence s_blk0(lk);
    rd_addr_in < 23'h2000 && block_protection_bits[136] == lk ##1 block_protection_bits[136] == lk;
  endsequence

  chk_refused_has_done: assert property (cmd_refused_out |-> cmd_done_out)
    else $error("refusal without done");
  chk_done_one_cycle: assert property (cmd_done_out |=> !cmd_done_out)
    else $error("done longer than one cycle");
  chk_lockdown_sticky: assert property (lockdown_status_flag_out |=> lockdown_status_flag_out)
    else $error("lock-down flag dropped without power cycle");
  chk_lockdown_freezes: assert property (lockdown_status_flag_out |=> $stable(block_protection_bits))
    else $error("protection bits changed under lock-down");
  chk_refused_keeps: assert property (cmd_refused_out |=> $stable(block_protection_bits) && $stable(plk))
    else $error("refused command changed a register");
  chk_refused_clears_wel: assert property (cmd_refused_out |=> !write_enable_latch_out)
    else $error("write enable left set");
  chk_perm_forces_wlock: assert property ((plk & ~block_protection_bits[135:0]) == 136'h0)
    else $error("permanent bit without write lock");
  // Permanent bits survive the power-on reset; only the factory reset clears them
  chk_perm_never_clears: assert property (@(posedge clock_in)
      disable iff (!rst_n_in || !factory_rst_n_in) ($past(plk) & ~plk) == 136'h0)
    else $error("permanent bit cleared");
  chk_readlock_zero: assert property (s_blk0(1'b1) |-> rd_data_out == 8'h00)
    else $error("read-locked block returned data");
  chk_readlock_pass: assert property (s_blk0(1'b0) |-> rd_data_out == $past(rd_data_in))
    else $error("unlocked read altered");
  chk_wlock_block0: assert property (rd_addr_in < 23'h2000 ##1 $stable(block_protection_bits)
      |-> wr_blocked_out == block_protection_bits[0])
    else $error("write lock of lowest block wrong");
endmodule

bind sfbp_core sfbp_core_asserts u_chk (.clock_in, .rst_n_in, .factory_rst_n_in, .rd_addr_in,
  .rd_data_in, .rd_data_out, .wr_blocked_out, .block_protection_bits_out,
  .permanent_lock_bits_out, .lockdown_status_flag_out, .write_enable_latch_out,
  .cmd_done_out, .cmd_refused_out);
`default_nettype wire

// [sfbp_host_model.sv]
// Purpose: Host serial controller that hands decoded commands to the core
// Assumes: Mode 0 by default, mode 3 on request; clock rests between frames
// Notes:   Released payload lines show the inverse, never the last value
`timescale 1ns/1ps
`default_nettype none

module sfbp_host_model (
  output var logic                sck_out,
  output var logic                valid_out,
  output var sfbp_pkg::sfbp_cmd_t cmd_out,
  output var logic [143:0]        data_out
);
  import sfbp_pkg::*;

  logic idle_hi;

  // Idle state of the bus before the first frame
  initial begin
    idle_hi = 1'b0;
    sck_out = 1'b0;
    valid_out = 1'b0;
    cmd_out = SFBP_CMD_NONE;
    data_out = '0;
  end

  // One frame: lines settle in the low half so the rising edge sees them stable
  // Change the resting level only between frames, with valid low
  task automatic set_idle(input logic hi);
    idle_hi = hi;
    sck_out = hi;
  endtask

  task automatic send(input sfbp_cmd_t c, input logic [143:0] d);
    #5;
    valid_out = 1'b1;
    cmd_out = c;
    data_out = d;
    sck_out = 1'b0;
    #24 sck_out = 1'b1;
    #24 sck_out = idle_hi;
    valid_out = 1'b0;
    cmd_out = SFBP_CMD_NONE;
    data_out = ~d;
  endtask
endmodule
`default_nettype wire

// [sfbp_core_bench.sv]
// Purpose: Command sequences against the block protection core
// Assumes: Host model frames commands; bench owns resets, pin and read port
// Notes:   Each command waits for its done pulse under a bound
`timescale 1ns/1ps
`default_nettype none

module sfbp_core_bench;
  import sfbp_pkg::*;
  localparam logic [143:0] RST_BPR = {8'h00, {136{1'b1}}};
  localparam logic [143:0] RD0 = {8'h01, 136'h0};
  logic              clock_in, rst_n_in, fac_rst_n, wp_n, sck, vld;
  logic              done, refd, ld, write_enable_latch, pen, cfg, quad, wb, rs;
  sfbp_cmd_t         lcmd;
  logic [143:0]      ldat, block_protection_bits;
  logic [135:0]      plk;
  logic [22:0]       rd_addr_in;
  logic [7:0]        rd_data_in, rdo;
  int                miscompares = 0;
  int                n_tests = 0;

  sfbp_host_model host (.sck_out(sck), .valid_out(vld), .cmd_out(lcmd), .data_out(ldat));

  sfbp_core dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .factory_rst_n_in(fac_rst_n),
    .sck_in(sck), .link_cmd_valid_in(vld), .link_cmd_in(lcmd), .link_data_in(ldat),
    .dual_read_mode_in(1'b0), .wp_n_in(wp_n), .rd_addr_in(rd_addr_in),
    .rd_data_in(rd_data_in), .rd_data_out(rdo), .wr_blocked_out(wb),
    .block_protection_bits_out(block_protection_bits), .permanent_lock_bits_out(plk),
    .lockdown_status_flag_out(ld), .write_enable_latch_out(write_enable_latch), .wp_pin_enable_bit_out(pen),
    .pin_config_bit_out(cfg), .quad_mode_out(quad), .cmd_done_out(done),
    .cmd_refused_out(refd));

  // 250 MHz core clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic chk(input string nm, input logic [143:0] s, input logic [143:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Frame and done wait run side by side, since done may land before the frame ends
  task automatic cmd(input sfbp_cmd_t c, input logic [143:0] d, input logic rf);
    int i;
    i = 0;
    fork
      host.send(c, d);
      while (done !== 1'b1 && i < 60) begin
        @(negedge clock_in);
        i++;
        rs = refd;
      end
    join
    if (i == 60) begin
      miscompares++;
      report_and_stop();
    end
    chk("refused", rs, rf);
  endtask

  // Write enable first, as a protection command needs a fresh one
  task automatic wc(input sfbp_cmd_t c, input logic [143:0] d, input logic rf);
    cmd(SFBP_CMD_WRITE_ENABLE_CMD, '0, 1'b0);
    cmd(c, d, rf);
  endtask

  task automatic rd(input logic [22:0] a, input logic [7:0] e, input logic eb);
    @(posedge clock_in) rd_addr_in <= a;
    @(posedge clock_in);
    @(negedge clock_in);
    chk("rdata", rdo, e);
    chk("wblocked", wb, eb);
  endtask

  // Pin changes go through a synchroniser, so give it time to land
  task automatic pin(input logic v);
    @(posedge clock_in) wp_n <= v;
    repeat (5) @(posedge clock_in);
  endtask

  task automatic pwr();
    @(posedge clock_in) rst_n_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    fac_rst_n <= 1'b1;
    repeat (2) @(negedge clock_in);
  endtask

  initial begin
    rst_n_in = 1'b0;
    fac_rst_n = 1'b0;
    wp_n = 1'b1;
    rd_addr_in = '0;
    rd_data_in = 8'h5a;
    rs = 1'b0;
    pwr();
    chk("bpr", block_protection_bits, RST_BPR);
    chk("plk", plk, '0);
    chk("wel", write_enable_latch, 1'b0);
    chk("quad", quad, 1'b0);
    cmd(SFBP_CMD_WRITE_PROTECTION_CMD, '0, 1'b1);
    chk("bpr", block_protection_bits, RST_BPR);
    host.set_idle(1'b1);
    cmd(SFBP_CMD_WRITE_ENABLE_CMD, '0, 1'b0);
    chk("wel", write_enable_latch, 1'b1);
    cmd(SFBP_CMD_WRDI, '0, 1'b0);
    chk("wel", write_enable_latch, 1'b0);
    host.set_idle(1'b0);
    wc(SFBP_CMD_WRITE_PROTECTION_CMD, RD0, 1'b0);
    chk("bpr", block_protection_bits, RD0);
    chk("wel", write_enable_latch, 1'b0);
    rd(23'h0, 8'h00, 1'b0);
    rd(23'h2000, 8'h5a, 1'b0);
    wc(SFBP_CMD_WCFG, 144'h2, 1'b0);
    chk("pen", pen, 1'b1);
    pin(1'b0);
    wc(SFBP_CMD_WRITE_PROTECTION_CMD, RST_BPR, 1'b1);
    wc(SFBP_CMD_WCFG, 144'h3, 1'b1);
    cmd(SFBP_CMD_EQUAD, '0, 1'b0);
    chk("quad", quad, 1'b1);
    wc(SFBP_CMD_WRITE_PROTECTION_CMD, RST_BPR, 1'b0);
    cmd(SFBP_CMD_XQUAD, '0, 1'b0);
    pin(1'b1);
    wc(SFBP_CMD_WCFG, 144'h3, 1'b0);
    chk("cfg", cfg, 1'b1);
    pin(1'b0);
    wc(SFBP_CMD_WRITE_PROTECTION_CMD, RD0 | RST_BPR, 1'b0);
    pin(1'b1);
    wc(SFBP_CMD_GUNLOCK, '0, 1'b0);
    chk("bpr", block_protection_bits, RD0);
    wc(SFBP_CMD_WPLK, 144'h8, 1'b0);
    chk("plk", plk, 136'h8);
    rd(23'h6000, 8'h5a, 1'b1);
    wc(SFBP_CMD_WPLK, '0, 1'b0);
    wc(SFBP_CMD_WRITE_PROTECTION_CMD, '0, 1'b0);
    chk("plk", plk, 136'h8);
    chk("bpr", block_protection_bits, 144'h8);
    cmd(SFBP_CMD_PROTECTION_LOCKDOWN_CMD, '0, 1'b1);
    wc(SFBP_CMD_PROTECTION_LOCKDOWN_CMD, '0, 1'b0);
    chk("ld", ld, 1'b1);
    wc(SFBP_CMD_WRITE_PROTECTION_CMD, RST_BPR, 1'b1);
    wc(SFBP_CMD_GUNLOCK, '0, 1'b1);
    wc(SFBP_CMD_WPLK, 144'h10, 1'b1);
    chk("plk", plk, 136'h8);
    pwr();
    chk("ld", ld, 1'b0);
    chk("bpr", block_protection_bits, RST_BPR);
    chk("plk", plk, 136'h8);
    chk("pen", pen, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
